// File: mmx_pkg.sv
// constants, types and encodings for the memory-to-memory move executer
// assumes one core clock; memory answers a read in the same cycle
package mmx_pkg;

    // ==========================================================
    // opcodes of the three move forms
    localparam logic [7:0] OPC_IMM_TO_PAGE = 8'h6e;
    localparam logic [7:0] OPC_PAGE_TO_PAGE = 8'h4e;
    localparam logic [7:0] OPC_IDX_TO_PAGE = 8'h7e;

    // ==========================================================
    // instruction lengths in bytes
    localparam logic [15:0] LEN_IMM_TO_PAGE = 16'h0003;
    localparam logic [15:0] LEN_PAGE_TO_PAGE = 16'h0003;
    localparam logic [15:0] LEN_IDX_TO_PAGE = 16'h0002;
    localparam logic [15:0] LEN_NONE = 16'h0001;

    // ==========================================================
    // bus cycles per form, opcode fetch included
    localparam logic [2:0] CYC_IMM_TO_PAGE = 3'h4;
    localparam logic [2:0] CYC_PAGE_TO_PAGE = 3'h5;
    localparam logic [2:0] CYC_IDX_TO_PAGE = 3'h4;

    // ==========================================================
    // direct page layout
    localparam logic [7:0] PAGE_HIGH = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [15:0] RST_HX = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CYC = 3'h0;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        FORM_NONE,
        FORM_IMM_TO_PAGE,
        FORM_PAGE_TO_PAGE,
        INDEXED_INCR_TO_PAGE_FORM
    } mmx_form_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_OPND1,
        ST_OPND2,
        ST_SOURCE,
        ST_WRITE
    } mmx_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } mmx_bus_req_t;

    localparam mmx_bus_req_t BUS_IDLE = '{addr: 16'h0000, rd: 1'b0, wr: 1'b0, wdata: 8'h00};

endpackage

// File: mmx_hx_step.sv
// post-increment of the 16-bit index pair
// pure logic; the caller decides when the result is taken
`timescale 1ns/1ps

module mmx_hx_step (
    input wire logic [15:0] hx_in,
    output logic [15:0] hx_out,
    output logic low_wrap
);

    logic [7:0] low_next;
    logic [7:0] high_next;

    // ==========================================================
    // carry from low byte into high byte
    always_comb begin
        low_wrap = (hx_in[7:0] == mmx_pkg::BYTE_MAX);
        low_next = hx_in[7:0] + 8'h01;
        high_next = hx_in[15:8] + {7'h00, low_wrap};
        hx_out = {high_next, low_next};
    end

endmodule

// File: mmx_exec.sv
// executer of the memory-to-memory move forms of the 8-bit core
// assumes the core hands over pc and index pair with START and
// that memory returns read data in the cycle the read is presented
`timescale 1ns/1ps

module mmx_exec (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic START,
    input wire logic [15:0] PC_IN,
    input wire logic [15:0] HX_IN,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [15:0] PC_OUT,
    output logic [15:0] HX_OUT,
    output mmx_pkg::mmx_form_t FORM,
    output logic [2:0] CYCLES,
    output mmx_pkg::mmx_bus_req_t BUS_REQ,
    input wire logic [7:0] BUS_RDATA
);

    // ==========================================================
    // decode helpers

    function automatic mmx_pkg::mmx_form_t form_of(input logic [7:0] opc);
        mmx_pkg::mmx_form_t f;
        f = mmx_pkg::FORM_NONE;
        case (opc)
            mmx_pkg::OPC_IMM_TO_PAGE: f = mmx_pkg::FORM_IMM_TO_PAGE;
            mmx_pkg::OPC_PAGE_TO_PAGE: f = mmx_pkg::FORM_PAGE_TO_PAGE;
            mmx_pkg::OPC_IDX_TO_PAGE: f = mmx_pkg::INDEXED_INCR_TO_PAGE_FORM;
            default: f = mmx_pkg::FORM_NONE;
        endcase
        return f;
    endfunction

    function automatic logic [15:0] page_addr(input logic [7:0] b);
        return {mmx_pkg::PAGE_HIGH, b};
    endfunction

    function automatic logic [15:0] len_of(input mmx_pkg::mmx_form_t f);
        logic [15:0] n;
        n = mmx_pkg::LEN_NONE;
        case (f)
            mmx_pkg::FORM_IMM_TO_PAGE: n = mmx_pkg::LEN_IMM_TO_PAGE;
            mmx_pkg::FORM_PAGE_TO_PAGE: n = mmx_pkg::LEN_PAGE_TO_PAGE;
            mmx_pkg::INDEXED_INCR_TO_PAGE_FORM: n = mmx_pkg::LEN_IDX_TO_PAGE;
            default: n = mmx_pkg::LEN_NONE;
        endcase
        return n;
    endfunction

    // ==========================================================
    // state
    mmx_pkg::mmx_state_t state_q;
    mmx_pkg::mmx_state_t state_d;
    mmx_pkg::mmx_form_t form_q;
    mmx_pkg::mmx_form_t form_d;
    mmx_pkg::mmx_form_t opc_form;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] hx_q;
    logic [15:0] hx_d;
    logic [15:0] hx_inc;
    logic [7:0] opnd1_q;
    logic [7:0] opnd1_d;
    logic [7:0] opnd2_q;
    logic [7:0] opnd2_d;
    logic [2:0] cyc_q;
    logic [2:0] cyc_d;
    logic [2:0] last_q;
    logic [2:0] last_d;
    logic illegal_q;
    logic illegal_d;
    mmx_pkg::mmx_bus_req_t bus_q;
    mmx_pkg::mmx_bus_req_t bus_d;

    assign opc_form = form_of(BUS_RDATA);

    mmx_hx_step u_hx_step (
        .hx_in(hx_q),
        .hx_out(hx_inc),
        .low_wrap()
    );

    // ==========================================================
    // sequencer
    // one bus access per state, so cycle counts equal state visits
    always_comb begin
        state_d = state_q;
        form_d = form_q;
        illegal_d = 1'b0;
        case (state_q)
            mmx_pkg::ST_IDLE: begin
                if (START) begin
                    state_d = mmx_pkg::ST_OPCODE;
                    form_d = mmx_pkg::FORM_NONE;
                end
            end
            mmx_pkg::ST_OPCODE: begin
                form_d = opc_form;
                if (opc_form == mmx_pkg::FORM_NONE) begin
                    state_d = mmx_pkg::ST_IDLE;
                    illegal_d = 1'b1;
                end else begin
                    state_d = mmx_pkg::ST_OPND1;
                end
            end
            mmx_pkg::ST_OPND1: begin
                // indexed form has one operand byte
                if (form_q == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) begin
                    state_d = mmx_pkg::ST_SOURCE;
                end else begin
                    state_d = mmx_pkg::ST_OPND2;
                end
            end
            mmx_pkg::ST_OPND2: begin
                if (form_q == mmx_pkg::FORM_IMM_TO_PAGE) begin
                    state_d = mmx_pkg::ST_WRITE;
                end else begin
                    state_d = mmx_pkg::ST_SOURCE;
                end
            end
            mmx_pkg::ST_SOURCE: begin
                state_d = mmx_pkg::ST_WRITE;
            end
            mmx_pkg::ST_WRITE: begin
                state_d = mmx_pkg::ST_IDLE;
            end
            default: begin
                state_d = mmx_pkg::ST_IDLE;
                form_d = mmx_pkg::FORM_NONE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_q <= mmx_pkg::ST_IDLE;
            form_q <= mmx_pkg::FORM_NONE;
            illegal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            form_q <= form_d;
            illegal_q <= illegal_d;
        end
    end

    // ==========================================================
    // operand capture and cycle count
    always_comb begin
        opnd1_d = opnd1_q;
        opnd2_d = opnd2_q;
        cyc_d = cyc_q;
        last_d = last_q;
        case (state_q)
            mmx_pkg::ST_IDLE: begin
                if (START) begin
                    cyc_d = mmx_pkg::RST_CYC;
                end
            end
            mmx_pkg::ST_OPND1: begin
                opnd1_d = BUS_RDATA;
            end
            mmx_pkg::ST_OPND2: begin
                opnd2_d = BUS_RDATA;
            end
            mmx_pkg::ST_SOURCE: begin
                // source byte held in opnd2 for the indexed form,
                // in opnd1 for page-to-page; accumulator never used
                if (form_q == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) begin
                    opnd2_d = BUS_RDATA;
                end else begin
                    opnd1_d = BUS_RDATA;
                end
            end
            default: begin
                opnd1_d = opnd1_q;
            end
        endcase
        if (state_q != mmx_pkg::ST_IDLE) begin
            cyc_d = cyc_q + 3'h1;
        end
        if (state_q == mmx_pkg::ST_WRITE || illegal_d) begin
            last_d = cyc_q + 3'h1;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            opnd1_q <= mmx_pkg::RST_BYTE;
            opnd2_q <= mmx_pkg::RST_BYTE;
            cyc_q <= mmx_pkg::RST_CYC;
            last_q <= mmx_pkg::RST_CYC;
        end else begin
            opnd1_q <= opnd1_d;
            opnd2_q <= opnd2_d;
            cyc_q <= cyc_d;
            last_q <= last_d;
        end
    end

    // ==========================================================
    // bus requests, registered so the access stands for its state
    always_comb begin
        bus_d = mmx_pkg::BUS_IDLE;
        case (state_q)
            mmx_pkg::ST_IDLE: begin
                if (START) begin
                    bus_d.addr = PC_IN;
                    bus_d.rd = 1'b1;
                end
            end
            mmx_pkg::ST_OPCODE: begin
                if (opc_form != mmx_pkg::FORM_NONE) begin
                    bus_d.addr = pc_q + 16'h0001;
                    bus_d.rd = 1'b1;
                end
            end
            mmx_pkg::ST_OPND1: begin
                if (form_q == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) begin
                    bus_d.addr = hx_q;
                end else begin
                    bus_d.addr = pc_q + 16'h0002;
                end
                bus_d.rd = 1'b1;
            end
            mmx_pkg::ST_OPND2: begin
                if (form_q == mmx_pkg::FORM_IMM_TO_PAGE) begin
                    bus_d.addr = page_addr(BUS_RDATA);
                    bus_d.wr = 1'b1;
                    bus_d.wdata = opnd1_q;
                end else begin
                    bus_d.addr = page_addr(opnd1_q);
                    bus_d.rd = 1'b1;
                end
            end
            mmx_pkg::ST_SOURCE: begin
                bus_d.wr = 1'b1;
                bus_d.wdata = BUS_RDATA;
                if (form_q == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) begin
                    bus_d.addr = page_addr(opnd1_q);
                end else begin
                    bus_d.addr = page_addr(opnd2_q);
                end
            end
            default: begin
                bus_d = mmx_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            bus_q <= mmx_pkg::BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    // ==========================================================
    // program counter and index pair
    // both take their final values on entry to the write state,
    // so they are already valid while DONE is high
    always_comb begin
        pc_d = pc_q;
        hx_d = hx_q;
        case (state_q)
            mmx_pkg::ST_IDLE: begin
                if (START) begin
                    pc_d = PC_IN;
                    hx_d = HX_IN;
                end
            end
            mmx_pkg::ST_OPCODE: begin
                if (opc_form == mmx_pkg::FORM_NONE) begin
                    pc_d = pc_q + len_of(opc_form);
                end
            end
            default: begin
                if (state_d == mmx_pkg::ST_WRITE) begin
                    pc_d = pc_q + len_of(form_q);
                    if (form_q == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) begin
                        hx_d = hx_inc;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pc_q <= mmx_pkg::RST_PC;
            hx_q <= mmx_pkg::RST_HX;
        end else begin
            pc_q <= pc_d;
            hx_q <= hx_d;
        end
    end

    // ==========================================================
    // outputs
    // no accumulator port exists, so it cannot be disturbed
    assign BUSY = (state_q != mmx_pkg::ST_IDLE);
    // done in fourth cycle for immediate form
    // done in fifth cycle for page-to-page form
    // done in fourth cycle for indexed form
    assign DONE = (state_q == mmx_pkg::ST_WRITE);
    assign ILLEGAL = illegal_q;
    assign PC_OUT = pc_q;
    assign HX_OUT = hx_q;
    assign FORM = form_q;
    assign CYCLES = last_q;
    assign BUS_REQ = bus_q;

endmodule

// File: mmx_exec_properties.sv
// concurrent checks on the move executer ports
// bound to mmx_exec; memory answers a read in the same cycle
`timescale 1ns/1ps
module mmx_exec_properties (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic START,
    input wire logic [15:0] PC_IN,
    input wire logic [15:0] HX_IN,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic ILLEGAL,
    input wire logic [15:0] PC_OUT,
    input wire logic [15:0] HX_OUT,
    input wire mmx_pkg::mmx_form_t FORM,
    input wire logic [2:0] CYCLES,
    input wire mmx_pkg::mmx_bus_req_t BUS_REQ,
    input wire logic [7:0] BUS_RDATA
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // ============================================================
    // steps of a move
    sequence s_take;
        START && !BUSY;
    endsequence
    sequence s_fetch(op);
        s_take ##1 (BUS_REQ.rd && BUS_RDATA == op);
    endsequence
    sequence s_put(d, a);
        DONE && BUS_REQ.wr && BUS_REQ.wdata == d && BUS_REQ.addr == {8'h00, a};
    endsequence
    // ============================================================
    // checks
    chk_fetch_addr: assert property (
        s_take |=> BUS_REQ.rd && BUS_REQ.addr == $past(PC_IN))
        else $error("opcode fetch address wrong");
    chk_imm_move: assert property (
        s_fetch(mmx_pkg::OPC_IMM_TO_PAGE) |-> !DONE [*3] ##1
        (s_put($past(BUS_RDATA, 2), $past(BUS_RDATA)) and PC_OUT == $past(PC_IN, 4) + 16'h0003))
        else $error("immediate move wrong");
    chk_page_move: assert property (
        s_fetch(mmx_pkg::OPC_PAGE_TO_PAGE) |-> !DONE [*3] ##1
        (!DONE && BUS_REQ.rd && BUS_REQ.addr == {8'h00, $past(BUS_RDATA, 2)}) ##1
        (s_put($past(BUS_RDATA), $past(BUS_RDATA, 2)) and PC_OUT == $past(PC_IN, 5) + 16'h0003))
        else $error("page move wrong");
    chk_idx_move: assert property (
        s_fetch(mmx_pkg::OPC_IDX_TO_PAGE) |-> !DONE [*2] ##1
        (!DONE && BUS_REQ.rd && BUS_REQ.addr == $past(HX_IN, 3)) ##1
        s_put($past(BUS_RDATA), $past(BUS_RDATA, 2)))
        else $error("indexed move wrong");
    chk_idx_incr: assert property (
        s_fetch(mmx_pkg::OPC_IDX_TO_PAGE) |-> ##3
        HX_OUT == $past(HX_IN, 4) + 16'h0001 && PC_OUT == $past(PC_IN, 4) + 16'h0002)
        else $error("index pair not advanced");
    chk_cycles_four: assert property (
        s_fetch(mmx_pkg::OPC_IMM_TO_PAGE) or s_fetch(mmx_pkg::OPC_IDX_TO_PAGE)
        |-> ##5 CYCLES == 3'h4)
        else $error("four cycle count wrong");
    chk_cycles_five: assert property (
        s_fetch(mmx_pkg::OPC_PAGE_TO_PAGE) |-> ##6 CYCLES == 3'h5)
        else $error("five cycle count wrong");
    chk_illegal_skip: assert property (
        s_take ##1 (BUS_REQ.rd && BUS_RDATA != mmx_pkg::OPC_IMM_TO_PAGE
        && BUS_RDATA != mmx_pkg::OPC_PAGE_TO_PAGE && BUS_RDATA != mmx_pkg::OPC_IDX_TO_PAGE)
        |=> ILLEGAL && !BUSY && !DONE && PC_OUT == $past(PC_IN, 2) + 16'h0001)
        else $error("unknown opcode not skipped");
    chk_page_write: assert property (
        BUS_REQ.wr |-> DONE && BUS_REQ.addr[15:8] == mmx_pkg::PAGE_HIGH)
        else $error("write outside direct page");
endmodule

// File: mmx_mem.sv
// byte memory standing behind the executer bus
// reads answer at once, writes land on the rising edge
`timescale 1ns/1ps
module mmx_mem (
    input wire logic clk,
    input wire mmx_pkg::mmx_bus_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    // ============================================================
    // unread cycles show the inverse so stale data never passes
    assign rdata = req.rd ? mem[req.addr] : ~mem[req.addr];
    always @(posedge clk) begin
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule

// File: mmx_exec_tb_top.sv
// self-checking bench for the move executer
// inputs change on the falling edge; mmx_mem serves the bus
`timescale 1ns/1ps
module mmx_exec_tb_top;
    logic MCLK, RESET, START, BUSY, DONE, ILLEGAL, p_ok;
    logic [15:0] PC_IN, HX_IN, PC_OUT, HX_OUT, e_pc, e_hx, e_dst, p_dst, pc, hx;
    logic [7:0] BUS_RDATA, e_dat, p_dat, op;
    logic [2:0] CYCLES, e_n, e_cyc, p_cyc;
    mmx_pkg::mmx_form_t FORM;
    mmx_pkg::mmx_bus_req_t BUS_REQ;
    int n_errors, checks, seed, n, i;
    mmx_exec u_mmx_exec (.MCLK(MCLK), .RESET(RESET), .START(START), .PC_IN(PC_IN),
        .HX_IN(HX_IN), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .PC_OUT(PC_OUT),
        .HX_OUT(HX_OUT), .FORM(FORM), .CYCLES(CYCLES), .BUS_REQ(BUS_REQ),
        .BUS_RDATA(BUS_RDATA));
    mmx_mem u_mmx_mem (.clk(MCLK), .req(BUS_REQ), .rdata(BUS_RDATA));
    // ============================================================
    // expectations and checks
    function automatic mmx_pkg::mmx_form_t form_of(input logic [7:0] o);
        case (o)
            mmx_pkg::OPC_IMM_TO_PAGE: return mmx_pkg::FORM_IMM_TO_PAGE;
            mmx_pkg::OPC_PAGE_TO_PAGE: return mmx_pkg::FORM_PAGE_TO_PAGE;
            mmx_pkg::OPC_IDX_TO_PAGE: return mmx_pkg::INDEXED_INCR_TO_PAGE_FORM;
            default: return mmx_pkg::FORM_NONE;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check_prev();
        if (p_ok) begin
            chk("cycles", CYCLES, p_cyc);
            chk("dest", u_mmx_mem.mem[p_dst], p_dat);
        end
    endtask
    // ============================================================
    // one move: program memory, then raise START
    task automatic go(input logic [7:0] o, input logic [15:0] a, input logic [15:0] x);
        logic [7:0] d, s;
        logic [15:0] src;
        mmx_pkg::mmx_form_t f;
        f = form_of(o);
        d = $random(seed) & 8'h7f;
        s = $random(seed) | 8'h80;
        src = (f == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) ? x : {8'h00, s};
        u_mmx_mem.mem[src] = $random(seed);
        u_mmx_mem.mem[a] = o;
        u_mmx_mem.mem[a + 16'h0001] = (f == mmx_pkg::FORM_PAGE_TO_PAGE) ? s
            : (f == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) ? d : 8'($random(seed));
        u_mmx_mem.mem[a + 16'h0002] = d;
        e_dst = {8'h00, d};
        e_dat = (f == mmx_pkg::FORM_IMM_TO_PAGE) ? u_mmx_mem.mem[a + 16'h0001]
            : u_mmx_mem.mem[src];
        if (f == mmx_pkg::FORM_NONE) begin
            e_dat = u_mmx_mem.mem[e_dst];
        end
        e_pc = a + ((f == mmx_pkg::FORM_NONE) ? 16'h0001
            : (f == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) ? 16'h0002 : 16'h0003);
        e_hx = (f == mmx_pkg::INDEXED_INCR_TO_PAGE_FORM) ? x + 16'h0001 : x;
        e_cyc = (f == mmx_pkg::FORM_PAGE_TO_PAGE) ? 3'h5 : (f == mmx_pkg::FORM_NONE) ? 3'h1 : 3'h4;
        e_n = (f == mmx_pkg::FORM_NONE) ? 3'h2 : e_cyc;
        START = 1'b1;
        PC_IN = a;
        HX_IN = x;
    endtask
    // poke raises a START mid-move that must be ignored
    task automatic run_out(input logic poke);
        @(negedge MCLK);
        START = 1'b0;
        n = 1;
        check_prev();
        while (DONE !== 1'b1 && ILLEGAL !== 1'b1 && n < 9) begin
            @(negedge MCLK);
            n++;
            START = poke && n == 2;
            PC_IN = START ? ~PC_IN : PC_IN;
        end
        if (n == 9) begin
            chk("timeout", 16'h0001, 16'h0000);
            finish_test();
        end
        chk("latency", n[15:0], e_n);
        chk("pc", PC_OUT, e_pc);
        chk("form", FORM, form_of(op));
        if (ILLEGAL !== 1'b1) begin
            chk("hx", HX_OUT, e_hx);
        end
        p_ok = 1'b1;
        p_cyc = e_cyc;
        p_dst = e_dst;
        p_dat = e_dat;
        // done cycle still counts as busy, so a start there would be dropped
        @(negedge MCLK);
    endtask
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    // ============================================================
    // main sequence: corners first, then random moves
    initial begin
        seed = 34979;
        n_errors = 0;
        checks = 0;
        p_ok = 1'b0;
        RESET = 1'b1;
        START = 1'b0;
        PC_IN = 16'h0000;
        HX_IN = 16'h0000;
        repeat (2) @(negedge MCLK);
        chk("reset flags", {BUSY, DONE, ILLEGAL, BUS_REQ.rd, BUS_REQ.wr}, 16'h0000);
        chk("reset pc", PC_OUT, 16'h0000);
        RESET = 1'b0;
        for (i = 0; i < 40; i++) begin
            n = $random(seed) & 3;
            op = (n == 0) ? mmx_pkg::OPC_IMM_TO_PAGE : (n == 1) ? mmx_pkg::OPC_PAGE_TO_PAGE
                : (n == 2) ? mmx_pkg::OPC_IDX_TO_PAGE : 8'($random(seed));
            pc = ($random(seed) & 16'h7fff) | 16'h0100;
            hx = $random(seed) | 16'h0100;
            op = (i == 0) ? mmx_pkg::OPC_IMM_TO_PAGE : (i == 1) ? mmx_pkg::OPC_PAGE_TO_PAGE
                : (i == 2 || i == 3) ? mmx_pkg::OPC_IDX_TO_PAGE : (i == 4) ? 8'h9d : op;
            hx = (i == 2) ? 16'h00ff : (i == 3) ? 16'hffff : hx;
            if ($random(seed) & 1) begin
                @(negedge MCLK);
            end
            go(op, pc, hx);
            run_out(i == 1);
            $display("test %0d op %h done", i, op);
        end
        @(negedge MCLK);
        check_prev();
        finish_test();
    end
endmodule
bind mmx_exec mmx_exec_properties u_mmx_exec_properties (.MCLK(MCLK), .RESET(RESET),
    .START(START), .PC_IN(PC_IN), .HX_IN(HX_IN), .BUSY(BUSY), .DONE(DONE),
    .ILLEGAL(ILLEGAL), .PC_OUT(PC_OUT), .HX_OUT(HX_OUT), .FORM(FORM), .CYCLES(CYCLES),
    .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA));
